// ---- inc/sercfg_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the serializer pin logic.
`ifndef SERCFG_CFG_SVH
`define SERCFG_CFG_SVH

`define SC_REG_CTRL 8'h00
`define SC_REG_STATUS 8'h04
`define SC_REG_FRAMES 8'h08

`define SC_CTRL_SWG_OVR 0
`define SC_CTRL_SWG_VAL 1
`define SC_CTRL_EMPH_EN 2
`define SC_CTRL_EDGE_OVR 3
`define SC_CTRL_EDGE_VAL 4
`define SC_CTRL_W 5
`define SC_CTRL_RESET 5'h00

`define SC_RESP_OKAY 2'h0
`define SC_RESP_SLVERR 2'h2

`define SC_CLK_MHZ 100
`define SC_BIT_NS 40
`define SC_BIT_CYC ((`SC_BIT_NS * `SC_CLK_MHZ) / 1000)
`define SC_FRAME_BITS 29
`define SC_FILT_LEN 3

`endif

// ---- inc/sercfg_pkg.sv ----
// Types shared by the serializer pin logic.
package sercfg_pkg;

    typedef enum logic [1:0] {
        SC_FILT_OFF = 2'b00,
        SC_FILT_ON = 2'b01,
        SC_COMPAT_A = 2'b10,
        SC_COMPAT_B = 2'b11
    } sercfg_mode_t;

    typedef enum logic {
        SC_IDLE = 1'b0,
        SC_SHIFT = 1'b1
    } sercfg_state_t;

endpackage : sercfg_pkg

// ---- inc/sercfg_cap_if.sv ----
// Interface carrying captured parallel words from the capture stage to the core.
`timescale 1ns/1ps
`default_nettype none

interface sercfg_cap_if;
    logic [23:0] data;
    logic [2:0] ctrl;
    logic valid;
    logic edge_rise;
    logic filter_on;

    modport cap (output data, output ctrl, output valid, input edge_rise, input filter_on);
    modport core (input data, input ctrl, input valid, output edge_rise, output filter_on);
endinterface : sercfg_cap_if

`default_nettype wire

// ---- design/sercfg_capture.sv ----
// Synchronises the parallel pins, picks the strobe edge and filters the data enable and hsync inputs.
`timescale 1ns/1ps
`default_nettype none
`include "sercfg_cfg.svh"

module sercfg_capture (
    // Clock and reset.
    input wire logic aclk,
    input wire logic rst,
    // Raw parallel pins.
    input wire logic pclk_pin,
    input wire logic [23:0] data_pin,
    input wire logic [2:0] ctrl_pin,
    // Captured words toward the core.
    sercfg_cap_if.cap cap
);
    import sercfg_pkg::*;

    logic [27:0] meta_q;
    logic [27:0] sync_q;
    logic clk_prev_q;
    logic clk_prev_d;
    logic [23:0] data_q;
    logic [23:0] data_d;
    logic [2:0] ctrl_q;
    logic [2:0] ctrl_d;
    logic valid_q;
    logic valid_d;
    logic [1:0] cnt_q [2];
    logic [1:0] cnt_d [2];
    logic strobe;

    // Two flops on every pin before any logic looks at it.
    always_ff @(posedge aclk) begin
        meta_q <= {pclk_pin, ctrl_pin, data_pin};
        sync_q <= meta_q;
    end

    // Strobe on the selected edge of the synchronised parallel clock.
    assign strobe = cap.edge_rise ? (sync_q[27] & ~clk_prev_q)
                                  : (~sync_q[27] & clk_prev_q);

    // Capture data and vsync as sampled; data enable and hsync pass the filter.
    always_comb begin
        clk_prev_d = sync_q[27];
        data_d = data_q;
        ctrl_d = ctrl_q;
        valid_d = 1'b0;
        cnt_d = cnt_q;
        if (strobe) begin
            data_d = sync_q[23:0];
            ctrl_d[2] = sync_q[26];
            valid_d = 1'b1;
            for (int i = 0; i < 2; i++) begin
                if (!cap.filter_on || sync_q[24 + i] == ctrl_q[i]) begin
                    ctrl_d[i] = sync_q[24 + i];
                    cnt_d[i] = 2'h0;
                end else if (cnt_q[i] == 2'(`SC_FILT_LEN - 1)) begin
                    ctrl_d[i] = sync_q[24 + i];
                    cnt_d[i] = 2'h0;
                end else begin
                    cnt_d[i] = cnt_q[i] + 2'h1;
                end
            end
        end
    end

    // Capture registers.
    always_ff @(posedge aclk) begin
        if (rst) begin
            clk_prev_q <= 1'b0;
            data_q <= 24'h000000;
            ctrl_q <= 3'h0;
            valid_q <= 1'b0;
            cnt_q <= '{2'h0, 2'h0};
        end else begin
            clk_prev_q <= clk_prev_d;
            data_q <= data_d;
            ctrl_q <= ctrl_d;
            valid_q <= valid_d;
            cnt_q <= cnt_d;
        end
    end

    assign cap.data = data_q;
    assign cap.ctrl = ctrl_q;
    assign cap.valid = valid_q;
endmodule : sercfg_capture

`default_nettype wire

// ---- design/sercfg_top.sv ----
// Pin-level control, configuration registers and serial framing of the link transmitter.
// Operation
// - Edge-select 1 captures inputs on rising clock edge, 0 on falling edge.
// - Power-down input high: normal operation, captured data serialized onto output pair.
// - Powered down: serial clock PLL stopped, all control registers held in reset.
// - Swing select 1 picks high swing, 0 low swing; register may override.
// - Emphasis off when pin floats; pin strap or register may enable it.
// - Mode 00 filter off, 01 filter on, 10 and 11 legacy compatibility.
// - Self-test input 0 normal, 1 built-in link self-test.
`timescale 1ns/1ps
`default_nettype none
`include "sercfg_cfg.svh"

module sercfg_top (
    // System clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Parallel source pins.
    input wire logic parallel_clock_in,
    input wire logic [23:0] parallel_data_in,
    input wire logic ctrl_in_data_enable,
    input wire logic ctrl_in_hsync,
    input wire logic ctrl_in_vsync,
    // Configuration pins.
    input wire logic power_down_n,
    input wire logic strobe_edge_select,
    input wire logic swing_select,
    input wire logic tx_emphasis_ctrl,
    input wire logic [1:0] link_mode,
    input wire logic self_test_enable,
    // AXI4-Lite write channels.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial link and driver controls.
    output logic serial_out_p,
    output logic serial_out_n,
    output logic pll_enable,
    output logic swing_high,
    output logic emphasis_on,
    output logic self_test_active,
    output sercfg_pkg::sercfg_mode_t link_mode_active
);
    import sercfg_pkg::*;

    logic [6:0] pin_meta_q;
    logic [6:0] pin_sync_q;
    logic pd_n;
    logic soft_rst;
    logic swing_eff;
    logic emph_eff;
    logic edge_eff;
    sercfg_mode_t mode_pin;
    logic [`SC_CTRL_W-1:0] ctrl_q;
    logic [`SC_CTRL_W-1:0] ctrl_d;
    logic aw_got_q;
    logic aw_got_d;
    logic w_got_q;
    logic w_got_d;
    logic [7:0] waddr_q;
    logic [7:0] waddr_d;
    logic [7:0] wbyte_q;
    logic [7:0] wbyte_d;
    logic wstb_q;
    logic wstb_d;
    logic bvalid_q;
    logic bvalid_d;
    logic [1:0] bresp_q;
    logic [1:0] bresp_d;
    logic rvalid_q;
    logic rvalid_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0] rresp_q;
    logic [1:0] rresp_d;
    sercfg_state_t state_q;
    sercfg_state_t state_d;
    logic [2:0] div_q;
    logic [2:0] div_d;
    logic [4:0] bit_q;
    logic [4:0] bit_d;
    logic [`SC_FRAME_BITS-1:0] shift_q;
    logic [`SC_FRAME_BITS-1:0] shift_d;
    logic [26:0] hold_q;
    logic [26:0] hold_d;
    logic [23:0] pattern_q;
    logic [23:0] pattern_d;
    logic [15:0] frames_q;
    logic [15:0] frames_d;
    logic out_p_q;
    logic out_p_d;
    logic out_n_q;
    logic out_n_d;
    logic pll_q;
    logic bit_en;
    sercfg_cap_if cap_bus ();

    // Configuration pins pass two flops; the synchronisers are cleared only by aresetn.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_q <= 7'h00;
            pin_sync_q <= 7'h00;
        end else begin
            pin_meta_q <= {self_test_enable, link_mode, tx_emphasis_ctrl, swing_select,
                           strobe_edge_select, power_down_n};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Power-down acts as a reset of every control register and of the framer.
    assign pd_n = pin_sync_q[0];
    assign soft_rst = ~aresetn | ~pd_n;
    assign mode_pin = sercfg_mode_t'(pin_sync_q[5:4]);

    // Effective settings: register overrides swing and edge, either source enables emphasis.
    assign swing_eff = ctrl_q[`SC_CTRL_SWG_OVR] ? ctrl_q[`SC_CTRL_SWG_VAL]
                                                : pin_sync_q[2];
    assign emph_eff = ctrl_q[`SC_CTRL_EMPH_EN] | ~pin_sync_q[3];
    assign edge_eff = ctrl_q[`SC_CTRL_EDGE_OVR] ? ctrl_q[`SC_CTRL_EDGE_VAL]
                                                : pin_sync_q[1];
    assign cap_bus.edge_rise = edge_eff;
    assign cap_bus.filter_on = (mode_pin == SC_FILT_ON);

    // Capture stage for the parallel source.
    sercfg_capture u_capture (
        .aclk(aclk),
        .rst(soft_rst),
        .pclk_pin(parallel_clock_in),
        .data_pin(parallel_data_in),
        .ctrl_pin({ctrl_in_vsync, ctrl_in_hsync, ctrl_in_data_enable}),
        .cap(cap_bus.cap)
    );

    // AXI4-Lite slave: address and data taken in either order, response after both.
    always_comb begin
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        waddr_d = waddr_q;
        wbyte_d = wbyte_q;
        wstb_d = wstb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        ctrl_d = ctrl_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_d = 1'b1;
            waddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_d = 1'b1;
            wbyte_d = s_axi_wdata[7:0];
            wstb_d = s_axi_wstrb[0];
        end
        if (aw_got_q && w_got_q) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            if (waddr_q == `SC_REG_CTRL) begin
                bresp_d = `SC_RESP_OKAY;
                if (wstb_q) begin
                    ctrl_d = wbyte_q[`SC_CTRL_W-1:0];
                end
            end else if (waddr_q == `SC_REG_STATUS || waddr_q == `SC_REG_FRAMES) begin
                bresp_d = `SC_RESP_OKAY;
            end else begin
                bresp_d = `SC_RESP_SLVERR;
            end
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = `SC_RESP_OKAY;
            if (s_axi_araddr == `SC_REG_CTRL) begin
                rdata_d = {27'h0000000, ctrl_q};
            end else if (s_axi_araddr == `SC_REG_STATUS) begin
                rdata_d = {24'h000000, state_q, pll_q, pin_sync_q[6], mode_pin,
                           edge_eff, emph_eff, swing_eff};
            end else if (s_axi_araddr == `SC_REG_FRAMES) begin
                rdata_d = {16'h0000, frames_q};
            end else begin
                rdata_d = 32'h00000000;
                rresp_d = `SC_RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // Register file state; held at defaults while powered down.
    always_ff @(posedge aclk) begin
        if (soft_rst) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= 8'h00;
            wbyte_q <= 8'h00;
            wstb_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `SC_RESP_OKAY;
            ctrl_q <= `SC_CTRL_RESET;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `SC_RESP_OKAY;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            waddr_q <= waddr_d;
            wbyte_q <= wbyte_d;
            wstb_q <= wstb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            ctrl_q <= ctrl_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_awready = ~aw_got_q & ~bvalid_q;
    assign s_axi_wready = ~w_got_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Bit-rate enable from the divider.
    assign bit_en = (div_q == 3'(`SC_BIT_CYC - 1));

    // Framer: marker bits, then data, then control, least significant bit first.
    always_comb begin
        div_d = bit_en ? 3'h0 : div_q + 3'h1;
        state_d = state_q;
        bit_d = bit_q;
        shift_d = shift_q;
        hold_d = cap_bus.valid ? {cap_bus.ctrl, cap_bus.data} : hold_q;
        pattern_d = pattern_q;
        frames_d = frames_q;
        out_p_d = out_p_q;
        out_n_d = out_n_q;
        if (bit_en) begin
            if (state_q == SC_IDLE || bit_q == 5'(`SC_FRAME_BITS - 1)) begin
                state_d = SC_SHIFT;
                bit_d = 5'h00;
                frames_d = frames_q + 16'h0001;
                if (pin_sync_q[6]) begin
                    shift_d = {3'h0, pattern_q, 2'b01};
                    pattern_d = pattern_q + 24'h000001;
                end else begin
                    shift_d = {hold_q, 2'b01};
                end
            end else begin
                bit_d = bit_q + 5'h01;
                shift_d = {1'b0, shift_q[`SC_FRAME_BITS-1:1]};
            end
            out_p_d = (state_q == SC_SHIFT) ? shift_q[0] : 1'b1;
            out_n_d = (state_q == SC_SHIFT) ? ~shift_q[0] : 1'b0;
        end
    end

    // Framer state; both outputs high and PLL stopped while powered down.
    always_ff @(posedge aclk) begin
        if (soft_rst) begin
            div_q <= 3'h0;
            state_q <= SC_IDLE;
            bit_q <= 5'h00;
            shift_q <= '0;
            hold_q <= 27'h0000000;
            pattern_q <= 24'h000000;
            frames_q <= 16'h0000;
            out_p_q <= 1'b1;
            out_n_q <= 1'b1;
            pll_q <= 1'b0;
        end else begin
            div_q <= div_d;
            state_q <= state_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            hold_q <= hold_d;
            pattern_q <= pattern_d;
            frames_q <= frames_d;
            out_p_q <= out_p_d;
            out_n_q <= out_n_d;
            pll_q <= 1'b1;
        end
    end

    assign serial_out_p = out_p_q;
    assign serial_out_n = out_n_q;
    assign pll_enable = pll_q;

    // Driver and mode indications, registered.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swing_high <= 1'b0;
            emphasis_on <= 1'b0;
            self_test_active <= 1'b0;
            link_mode_active <= SC_FILT_OFF;
        end else begin
            swing_high <= swing_eff;
            emphasis_on <= emph_eff;
            self_test_active <= pin_sync_q[6] & pd_n;
            link_mode_active <= mode_pin;
        end
    end
endmodule : sercfg_top

`default_nettype wire

// ---- tb/sercfg_rx_model.sv ----
// Behavioural receiver that recovers frames from the serial pair.
`timescale 1ns/1ps
`default_nettype none
`include "sercfg_cfg.svh"

module sercfg_rx_model (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Serial pair from the transmitter.
    input wire logic serial_p,
    input wire logic serial_n,
    // Last frame recovered and error tally.
    output logic [23:0] rx_data,
    output logic [2:0] rx_ctrl,
    output logic [15:0] rx_frames,
    output logic [15:0] rx_bad
);
    int cnt;
    int idx;
    logic [28:0] sh;

    // Both lines high means no link; the first split opens one idle bit, then frames follow.
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_frames <= 16'h0000;
            rx_bad <= 16'h0000;
        end
        if (!aresetn || (serial_p && serial_n)) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
            idx = (cnt / `SC_BIT_CYC - 1) % `SC_FRAME_BITS;
            // Each bit is sampled mid-period; the pair must stay complementary.
            if (cnt >= `SC_BIT_CYC && cnt % `SC_BIT_CYC == `SC_BIT_CYC / 2) begin
                sh[idx] = serial_p;
                if (serial_n !== ~serial_p) rx_bad <= rx_bad + 16'h0001;
                if (idx == `SC_FRAME_BITS - 1) begin
                    rx_data <= sh[25:2];
                    rx_ctrl <= sh[28:26];
                    rx_frames <= rx_frames + 16'h0001;
                    if (sh[1:0] !== 2'b01) rx_bad <= rx_bad + 16'h0001;
                end
            end
        end
    end
endmodule : sercfg_rx_model

`default_nettype wire

// ---- tb/sercfg_props.sv ----
// Concurrent checks on the serializer pin logic, bound to its top module.
`timescale 1ns/1ps
`default_nettype none

module sercfg_props (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Configuration pins.
    input wire logic power_down_n,
    input wire logic swing_select,
    input wire logic tx_emphasis_ctrl,
    input wire logic [1:0] link_mode,
    input wire logic self_test_enable,
    // Driver outputs.
    input wire logic serial_out_p,
    input wire logic serial_out_n,
    input wire logic pll_enable,
    input wire logic swing_high,
    input wire logic emphasis_on,
    input wire logic self_test_active,
    input wire sercfg_pkg::sercfg_mode_t link_mode_active
);
    import sercfg_pkg::*;
    logic [4:0] run_q;
    logic [4:0] run_d;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Counts cycles of uninterrupted normal operation, saturating at the top.
    always_comb begin
        run_d = run_q;
        if (!power_down_n) begin
            run_d = 5'h00;
        end else if (run_q != 5'h1F) begin
            run_d = run_q + 5'h01;
        end
    end
    always_ff @(posedge aclk) begin
        run_q <= aresetn ? run_d : 5'h00;
    end

    sequence pd_held;
        !power_down_n [*7];
    endsequence
    sequence pd_release;
        !power_down_n ##1 power_down_n [*7];
    endsequence

    chk_pd_lines_high: assert property (pd_held |-> serial_out_p && serial_out_n)
        else $error("serial lines not both high while powered down");
    chk_pd_pll_off: assert property (pd_held |-> !pll_enable)
        else $error("pll still enabled while powered down");
    chk_pd_swing_pin: assert property ((!power_down_n && swing_select) [*8] |-> swing_high)
        else $error("swing not taken from pin while registers are reset");
    chk_run_split: assert property (run_q == 5'h1F |-> serial_out_p != serial_out_n)
        else $error("serial pair not complementary in normal operation");
    chk_pll_restart: assert property (pd_release |-> pll_enable)
        else $error("pll not restarted after power-down release");
    chk_emph_strap: assert property ((!tx_emphasis_ctrl) [*6] |-> emphasis_on)
        else $error("emphasis off although strap pulls low");
    chk_mode_follow: assert property ($stable(link_mode) [*6] |-> link_mode_active == link_mode)
        else $error("active mode differs from mode pins");
    chk_selftest_pin: assert property ($stable(self_test_enable) [*6]
        |-> self_test_active == self_test_enable)
        else $error("self-test state differs from its pin");
endmodule : sercfg_props

bind sercfg_top sercfg_props u_props (
    .aclk(aclk), .aresetn(aresetn), .power_down_n(power_down_n),
    .swing_select(swing_select), .tx_emphasis_ctrl(tx_emphasis_ctrl), .link_mode(link_mode),
    .self_test_enable(self_test_enable), .serial_out_p(serial_out_p),
    .serial_out_n(serial_out_n), .pll_enable(pll_enable), .swing_high(swing_high),
    .emphasis_on(emphasis_on), .self_test_active(self_test_active),
    .link_mode_active(link_mode_active)
);

`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the serializer pin logic with a behavioural receiver.
`timescale 1ns/1ps
`default_nettype none
`include "sercfg_cfg.svh"
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t %s", $time, m); end end

module tb_top;
    import sercfg_pkg::*;
    localparam logic [23:0] WA = 24'hA5C30F;
    localparam logic [23:0] WB = 24'h5A3CF0;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic pclk = 1'b0;
    logic [23:0] pdata = 24'h000000;
    logic [2:0] pctrl = 3'h0;
    logic pd_n = 1'b0;
    logic edge_sel = 1'b1;
    logic swing_sel = 1'b0;
    logic emph_strap = 1'b1;
    logic [1:0] mode = 2'h0;
    logic st_en = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sp, sn, pll, swing_hi, emph_on, st_act;
    logic [1:0] bresp, rresp;
    sercfg_mode_t mode_act;
    logic [23:0] rx_data;
    logic [2:0] rx_ctrl;
    logic [15:0] rx_frames, rx_bad;
    int bad_count = 0;
    int n_checks = 0;

    // Free-running system clock.
    always #5 aclk = ~aclk;

    sercfg_top dut (
        .aclk(aclk), .aresetn(aresetn), .parallel_clock_in(pclk), .parallel_data_in(pdata),
        .ctrl_in_data_enable(pctrl[0]), .ctrl_in_hsync(pctrl[1]), .ctrl_in_vsync(pctrl[2]),
        .power_down_n(pd_n), .strobe_edge_select(edge_sel), .swing_select(swing_sel),
        .tx_emphasis_ctrl(emph_strap), .link_mode(mode), .self_test_enable(st_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .serial_out_p(sp), .serial_out_n(sn), .pll_enable(pll), .swing_high(swing_hi),
        .emphasis_on(emph_on), .self_test_active(st_act), .link_mode_active(mode_act)
    );

    sercfg_rx_model rx (
        .aclk(aclk), .aresetn(aresetn), .serial_p(sp), .serial_n(sn),
        .rx_data(rx_data), .rx_ctrl(rx_ctrl), .rx_frames(rx_frames), .rx_bad(rx_bad)
    );

    // Prints the tallies and the verdict, then ends the run.
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // One bus write; address and data are released separately as each is taken.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                bready <= 1'b0;
                `CHK(bresp, er, "write response")
                return;
            end
        end
        bad_count++;
        $display("[FAIL] %0t write timed out", $time);
        final_report();
    endtask : axi_write

    // One bus read with expected data and response.
    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_ok;
        ar_ok = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (!ar_ok && arready) begin
                ar_ok = 1'b1;
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                rready <= 1'b0;
                `CHK(rdata, ed, "read data")
                `CHK(rresp, er, "read response")
                return;
            end
        end
        bad_count++;
        $display("[FAIL] %0t read timed out", $time);
        final_report();
    endtask : axi_read

    // Slow pixel clock: word a is set up before each rise, word b before each fall.
    task automatic pixels(input logic [2:0] c, input logic [23:0] a, input logic [23:0] b);
        pctrl <= c;
        repeat (12) begin
            @(posedge aclk);
            pdata <= a;
            repeat (10) @(posedge aclk);
            pclk <= 1'b1;
            repeat (10) @(posedge aclk);
            pdata <= b;
            repeat (10) @(posedge aclk);
            pclk <= 1'b0;
            repeat (9) @(posedge aclk);
        end
    endtask : pixels

    // Main sequence of tests.
    initial begin
        repeat (16) @(posedge aclk);
        `CHK(sp & sn, 1'b1, "lines high in reset")
        `CHK(pll, 1'b0, "pll off in reset")
        aresetn <= 1'b1;
        pd_n <= 1'b1;
        repeat (40) @(posedge aclk);
        `CHK(pll, 1'b1, "pll running")
        axi_read(`SC_REG_CTRL, 32'h00000000, `SC_RESP_OKAY);
        axi_read(`SC_REG_STATUS, 32'h000000C4, `SC_RESP_OKAY);
        axi_read(8'h0C, 32'h00000000, `SC_RESP_SLVERR);
        axi_write(8'h20, 32'h0000001F, `SC_RESP_SLVERR);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            mode <= i[1:0];
            st_en <= i[0];
            swing_sel <= i[1];
            emph_strap <= i[0];
            repeat (8) @(posedge aclk);
            `CHK(mode_act, i[1:0], "mode")
            `CHK(st_act, i[0], "self-test")
            `CHK(swing_hi, i[1], "swing pin")
            `CHK(emph_on, ~i[0], "emphasis strap")
        end
        mode <= 2'h0;
        st_en <= 1'b0;
        swing_sel <= 1'b0;
        emph_strap <= 1'b1;
        axi_write(`SC_REG_CTRL, 32'h00000003, `SC_RESP_OKAY);
        repeat (4) @(posedge aclk);
        `CHK(swing_hi, 1'b1, "swing override")
        axi_write(`SC_REG_CTRL, 32'h00000004, `SC_RESP_OKAY);
        repeat (4) @(posedge aclk);
        `CHK(swing_hi, 1'b0, "swing back to pin")
        `CHK(emph_on, 1'b1, "emphasis register")
        axi_read(`SC_REG_CTRL, 32'h00000004, `SC_RESP_OKAY);
        $display("test pins done");
        axi_write(`SC_REG_CTRL, 32'h00000000, `SC_RESP_OKAY);
        pixels(3'h5, WA, WB);
        `CHK(rx_data, WA, "rising capture")
        `CHK(rx_ctrl, 3'h5, "control bits")
        edge_sel <= 1'b0;
        pixels(3'h5, WA, WB);
        `CHK(rx_data, WB, "falling capture")
        axi_write(`SC_REG_CTRL, 32'h00000018, `SC_RESP_OKAY);
        pixels(3'h5, WA, WB);
        `CHK(rx_data, WA, "edge override")
        mode <= 2'h1;
        pixels(3'h2, WA, WB);
        `CHK(rx_ctrl, 3'h2, "filtered control")
        mode <= 2'h0;
        st_en <= 1'b1;
        pixels(3'h5, WA, WB);
        `CHK(rx_ctrl, 3'h0, "self-test frame")
        st_en <= 1'b0;
        `CHK(rx_bad, 16'h0000, "frame errors")
        `CHK(rx_frames != 16'h0000, 1'b1, "frames seen")
        $display("test capture done");
        swing_sel <= 1'b1;
        axi_write(`SC_REG_CTRL, 32'h00000001, `SC_RESP_OKAY);
        repeat (4) @(posedge aclk);
        `CHK(swing_hi, 1'b0, "override low")
        pd_n <= 1'b0;
        repeat (8) @(posedge aclk);
        `CHK(sp & sn, 1'b1, "lines high in power-down")
        `CHK(pll, 1'b0, "pll stopped")
        `CHK(swing_hi, 1'b1, "registers reset")
        pd_n <= 1'b1;
        repeat (40) @(posedge aclk);
        `CHK(pll, 1'b1, "pll restarted")
        `CHK(swing_hi, 1'b1, "pin governs")
        axi_read(`SC_REG_CTRL, 32'h00000000, `SC_RESP_OKAY);
        $display("test power-down done");
        final_report();
    end
endmodule : tb_top

`default_nettype wire
